// *** logic/force_reset_gen.v ***
`timescale 1ns/1ns
`include "serial_debug_defs.vh"
// Stretches a one-cycle request into a fixed-width target reset pulse
module force_reset_gen #(
    parameter [3:0] PULSE_CYCLES = `FORCE_RESET_PULSE
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire trigger_i,
    output reg target_reset_o
);
    reg [3:0] count_reg; // Remaining pulse cycles
    // Count down while the pulse is active
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= 4'h0;
            target_reset_o <= 1'b0;
        end else if (trigger_i) begin
            count_reg <= PULSE_CYCLES - 4'h1;
            target_reset_o <= 1'b1;
        end else if (count_reg != 4'h0) begin
            count_reg <= count_reg - 4'h1;
        end else begin
            target_reset_o <= 1'b0;
        end
    end
endmodule

// *** logic/serial_debug_defs.vh ***
`ifndef SERIAL_DEBUG_DEFS_VH
`define SERIAL_DEBUG_DEFS_VH
// Status/control bit positions
`define STAT_WAIT_STOP_BIT 2
`define STAT_SLEEP_FAIL_BIT 1
`define STAT_SLOW_FAIL_BIT 0
`define CTRL_FORCE_TAG_BIT 3
`define CTRL_MATCH_EN_BIT 7
`define CTRL_DEBUG_ACTIVE_BIT 6
// Reset values
`define STATUS_CTRL_RESET 8'h00
`define MATCH_ADDR_RESET 16'h0000
// Force-reset register
`define FORCE_RESET_BIT 0
`define FORCE_RESET_READ 8'h00
// Width of the generated target reset pulse, cycles
`define FORCE_RESET_PULSE 4'h8
// Command codes on the decoded command port
`define CMD_NONE 4'h0
`define CMD_HALT 4'h1
`define CMD_STATUS 4'h2
`define CMD_CTRL_LOAD 4'h3
`define CMD_MATCH_FETCH 4'h4
`define CMD_MATCH_LOAD 4'h5
`define CMD_MEM_STORE 4'h6
`define CMD_MEM_FETCH 4'h7
`define CMD_FORCE_FETCH 4'h8
`endif

// *** logic/serial_debug_status_regs.v ***
`timescale 1ns/1ns
`include "serial_debug_defs.vh"
module serial_debug_status_regs (
    input wire sys_clk_i,
    input wire rst_i,
    input wire cmd_valid_i,
    input wire [3:0] cmd_code_i,
    input wire [15:0] cmd_data_i,
    input wire cpu_sleep_i,
    input wire cpu_sleep_enter_i,
    input wire cpu_force_reset_wr_i,
    input wire [7:0] cpu_force_reset_data_i,
    output reg resp_valid_o,
    output reg [15:0] resp_data_o,
    output reg cmd_rejected_o,
    output reg halt_req_o,
    output reg mem_cmd_o,
    output reg debug_active_o,
    output reg match_enable_o,
    output reg force_tag_select_o,
    output reg [15:0] match_addr_o,
    output reg target_reset_o
);
    // Pin-level CPU status passes two flops first
    reg sleep_meta_reg;
    reg sleep_sync_reg;
    reg enter_meta_reg;
    reg enter_sync_reg;
    // Status and control state
    reg wait_stop_reg;
    reg sleep_fail_reg;
    reg forced_from_sleep_reg;
    reg [7:0] ctrl_reg;
    reg [15:0] match_addr_reg;
    reg reset_trigger_reg; // One-cycle request to the stretcher
    // Stretched pulse back from the generator
    wire reset_pulse;
    // Command classes decoded from the code port
    wire is_mem;
    wire is_halt;
    wire blocked;
    wire [7:0] status_byte;
    // Memory-access style commands
    assign is_mem = (cmd_code_i == `CMD_MEM_STORE) || (cmd_code_i == `CMD_MEM_FETCH);
    assign is_halt = (cmd_code_i == `CMD_HALT);
    // Target asleep: only halt or status may proceed
    // Sleep is seen two cycles late; a command taken earlier still runs
    assign blocked = sleep_sync_reg && !is_halt && (cmd_code_i != `CMD_STATUS);
    // Status byte: control bits above, flags below, slow fail tied low
    // No slow memory on this target, so bit 0 never rises
    assign status_byte = {ctrl_reg[7:3], wait_stop_reg, sleep_fail_reg, 1'b0};

    // Synchronisers for the CPU sleep signals
    // Async CPU levels: only the second flop is read by logic
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_meta_reg <= 1'b0;
            sleep_sync_reg <= 1'b0;
            enter_meta_reg <= 1'b0;
            enter_sync_reg <= 1'b0;
        end else begin
            // Two stages per pin
            sleep_meta_reg <= cpu_sleep_i;
            sleep_sync_reg <= sleep_meta_reg;
            enter_meta_reg <= cpu_sleep_enter_i;
            enter_sync_reg <= enter_meta_reg;
        end
    end

    // Command decode, flags and registers
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Flags clear, no pending trigger, no answer
            wait_stop_reg <= 1'b0;
            sleep_fail_reg <= 1'b0;
            forced_from_sleep_reg <= 1'b0;
            ctrl_reg <= `STATUS_CTRL_RESET;
            match_addr_reg <= `MATCH_ADDR_RESET;
            reset_trigger_reg <= 1'b0;
            resp_valid_o <= 1'b0;
            resp_data_o <= 16'h0000;
            cmd_rejected_o <= 1'b0;
            halt_req_o <= 1'b0;
            mem_cmd_o <= 1'b0;
        end else begin
            // Defaults: pulses drop after one cycle
            resp_valid_o <= 1'b0;
            cmd_rejected_o <= 1'b0;
            halt_req_o <= 1'b0;
            mem_cmd_o <= 1'b0;
            reset_trigger_reg <= 1'b0;
            // Level follows sleep, or sticks after a forced halt
            wait_stop_reg <= sleep_sync_reg || forced_from_sleep_reg;
            // Resuming user code ends the forced-halt memory
            // Checked before decode, so it holds even when the load is refused
            if (cmd_valid_i && (cmd_code_i == `CMD_CTRL_LOAD) && !cmd_data_i[`CTRL_DEBUG_ACTIVE_BIT]) begin
                forced_from_sleep_reg <= 1'b0;
            end
            // Code and data are only looked at with valid high
            if (cmd_valid_i) begin
                // Asleep: refuse, and note a lost memory access
                if (blocked) begin
                    cmd_rejected_o <= 1'b1;
                    // Memory command lost to sleep: sticky fail
                    if (is_mem) begin
                        sleep_fail_reg <= 1'b1;
                    end
                end else begin
                    case (cmd_code_i)
                        // Halt into debug; leaving sleep this way is remembered
                        `CMD_HALT: begin
                            halt_req_o <= 1'b1;
                            ctrl_reg[`CTRL_DEBUG_ACTIVE_BIT] <= 1'b1;
                            // Halt from sleep keeps the wait-stop flag up
                            if (sleep_sync_reg) begin
                                forced_from_sleep_reg <= 1'b1;
                            end
                        end
                        // Status byte in the low half
                        `CMD_STATUS: begin
                            resp_valid_o <= 1'b1;
                            resp_data_o <= {8'h00, status_byte};
                        end
                        // Control load from the host
                        `CMD_CTRL_LOAD: begin
                            // Writable bits only; status flags stay hardware-owned
                            ctrl_reg[7:3] <= cmd_data_i[7:3];
                            // Load clears the fail flag; only memory commands set it, so no race
                            sleep_fail_reg <= 1'b0;
                        end
                        // Breakpoint address read back
                        `CMD_MATCH_FETCH: begin
                            resp_valid_o <= 1'b1;
                            resp_data_o <= match_addr_reg;
                        end
                        // Breakpoint address load, link only
                        `CMD_MATCH_LOAD: begin
                            match_addr_reg <= cmd_data_i;
                        end
                        // Store, standing for a write to the force-reset register
                        `CMD_MEM_STORE: begin
                            // Sleep entry racing the store: fail instead of access
                            if (enter_sync_reg) begin
                                sleep_fail_reg <= 1'b1;
                                cmd_rejected_o <= 1'b1;
                            end else begin
                                mem_cmd_o <= 1'b1;
                                // Debug-link write of one triggers target reset
                                reset_trigger_reg <= cmd_data_i[`FORCE_RESET_BIT];
                            end
                        end
                        // Fetch: same race check as the store
                        `CMD_MEM_FETCH: begin
                            if (enter_sync_reg) begin
                                sleep_fail_reg <= 1'b1;
                                cmd_rejected_o <= 1'b1;
                            end else begin
                                mem_cmd_o <= 1'b1;
                            end
                        end
                        // Force-reset register reads as zero
                        `CMD_FORCE_FETCH: begin
                            resp_valid_o <= 1'b1;
                            resp_data_o <= {8'h00, `FORCE_RESET_READ};
                        end
                        // Unknown codes are only refused
                        default: begin
                            cmd_rejected_o <= 1'b1;
                        end
                    endcase
                end
            end
            // CPU writes to the force-reset register are left unread on purpose:
            // only the store branch arms the trigger, so user code cannot
            // reset the target, nor cancel a reset asked for over the link
        end
    end

    // Registered copies of control state for the breakpoint logic
    // One cycle of extra latency, traded for outputs straight from flops
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Idle outputs in reset
            debug_active_o <= 1'b0;
            match_enable_o <= 1'b0;
            force_tag_select_o <= 1'b0;
            match_addr_o <= `MATCH_ADDR_RESET;
            target_reset_o <= 1'b0;
        end else begin
            // Control reaches the pins one cycle after the edge that takes a load
            debug_active_o <= ctrl_reg[`CTRL_DEBUG_ACTIVE_BIT];
            match_enable_o <= ctrl_reg[`CTRL_MATCH_EN_BIT];
            force_tag_select_o <= ctrl_reg[`CTRL_FORCE_TAG_BIT];
            match_addr_o <= match_addr_reg;
            target_reset_o <= reset_pulse;
        end
    end

    // Reset pulse stretcher
    // Fixed width, so a one-cycle store request still resets the target fully
    force_reset_gen #(
        .PULSE_CYCLES(`FORCE_RESET_PULSE)
    ) u_force_reset (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .trigger_i(reset_trigger_reg),
        .target_reset_o(reset_pulse)
    );
endmodule

// *** verif/debug_host_model.sv ***
`timescale 1ns/1ns
// Debug host: one command at a time, random idle gap after each
module debug_host_model (
    input wire sys_clk_i,
    input wire resp_valid_i,
    input wire [15:0] resp_data_i,
    input wire [2:0] pulse_i,
    output reg cmd_valid_o = 1'b0,
    output reg [3:0] cmd_code_o = 4'h0,
    output reg [15:0] cmd_data_o = 16'h0000
);
    // Hold until the taking edge; released lines show inverted values
    task send(input [3:0] code, input [15:0] data, output [15:0] r, output [3:0] f);
        @(posedge sys_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        cmd_data_o <= data;
        @(posedge sys_clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~code;
        cmd_data_o <= ~data;
        @(negedge sys_clk_i);
        r = resp_data_i;
        f = {resp_valid_i, pulse_i};
        repeat ($urandom_range(3, 1)) @(posedge sys_clk_i);
    endtask
endmodule

// *** verif/sdsr_chk.sv ***
`timescale 1ns/1ns
`include "serial_debug_defs.vh"
// Port-level checks of the debug status block
module sdsr_chk (
    input wire sys_clk_i,
    input wire rst_i,
    input wire cmd_valid_i,
    input wire [3:0] cmd_code_i,
    input wire [15:0] cmd_data_i,
    input wire cpu_sleep_i,
    input wire resp_valid_o,
    input wire [15:0] resp_data_o,
    input wire cmd_rejected_o,
    input wire halt_req_o,
    input wire [15:0] match_addr_o,
    input wire target_reset_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    stat_answer_a: assert property (cmd_valid_i && cmd_code_i == `CMD_STATUS |=> resp_valid_o && !resp_data_o[0])
        else $error("status answer wrong");
    fetch_match_a: assert property (cmd_valid_i && cmd_code_i == `CMD_MATCH_FETCH |=> cmd_rejected_o ||
        (resp_valid_o && resp_data_o == match_addr_o))
        else $error("match fetch wrong");
    load_match_a: assert property (cmd_valid_i && cmd_code_i == `CMD_MATCH_LOAD ##1 !cmd_rejected_o |=>
        match_addr_o == $past(cmd_data_i, 2))
        else $error("match load lost");
    force_read_a: assert property (cmd_valid_i && cmd_code_i == `CMD_FORCE_FETCH |=> cmd_rejected_o ||
        (resp_valid_o && resp_data_o == 16'h0000))
        else $error("force register not zero");
    reset_cause_a: assert property ($rose(target_reset_o) |-> $past(cmd_valid_i && cmd_code_i == `CMD_MEM_STORE && cmd_data_i[0], 3))
        else $error("target reset without store");
    reset_width_a: assert property ($rose(target_reset_o) |-> target_reset_o [*8] ##1 !target_reset_o)
        else $error("target reset width wrong");
    sleep_refuse_a: assert property (cpu_sleep_i [*4] ##0 (cmd_valid_i && cmd_code_i == `CMD_MEM_FETCH) |=> cmd_rejected_o)
        else $error("memory command ran in sleep");
    sleep_halt_a: assert property (cpu_sleep_i [*4] ##0 (cmd_valid_i && cmd_code_i == `CMD_HALT) |=> halt_req_o && !cmd_rejected_o)
        else $error("halt refused in sleep");
endmodule
bind serial_debug_status_regs sdsr_chk u_chk (.sys_clk_i, .rst_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i,
    .cpu_sleep_i, .resp_valid_o, .resp_data_o, .cmd_rejected_o, .halt_req_o, .match_addr_o, .target_reset_o);

// *** verif/serial_debug_status_regs_bench.sv ***
`timescale 1ns/1ns
`include "serial_debug_defs.vh"
module serial_debug_status_regs_bench;
    reg sys_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cpu_sleep_i = 1'b0;
    reg cpu_sleep_enter_i = 1'b0;
    reg cpu_force_reset_wr_i = 1'b0;
    reg [7:0] cpu_force_reset_data_i = 8'h00;
    wire cmd_valid_i, resp_valid_o, cmd_rejected_o, halt_req_o, mem_cmd_o;
    wire debug_active_o, match_enable_o, force_tag_select_o, target_reset_o;
    wire [3:0] cmd_code_i;
    wire [15:0] cmd_data_i, resp_data_o, match_addr_o;
    integer n_fail = 0;
    integer n_tests = 0;
    integer ctl = 0, ws = 0, sleep_access_fail = 0, i, a;
    logic [15:0] r;
    logic [3:0] f;
    always #4 sys_clk_i = ~sys_clk_i;
    debug_host_model host (.sys_clk_i(sys_clk_i), .resp_valid_i(resp_valid_o), .resp_data_i(resp_data_o),
        .pulse_i({cmd_rejected_o, halt_req_o, mem_cmd_o}), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
        .cmd_data_o(cmd_data_i));
    serial_debug_status_regs DUT (.sys_clk_i, .rst_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i, .cpu_sleep_i,
        .cpu_sleep_enter_i, .cpu_force_reset_wr_i, .cpu_force_reset_data_i, .resp_valid_o, .resp_data_o,
        .cmd_rejected_o, .halt_req_o, .mem_cmd_o, .debug_active_o, .match_enable_o, .force_tag_select_o,
        .match_addr_o, .target_reset_o);
    // Compare and count
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Status read against the bench model
    task stat;
        host.send(`CMD_STATUS, 16'h0000, r, f);
        chk(r, 16'(ctl & 248 | ws * 4 | sleep_access_fail * 2));
    endtask
    // Far beyond the few hundred cycles the sequence needs
    initial begin
        #80000;
        n_fail = n_fail + 1;
        complete_run;
    end
    initial begin
        void'($urandom(32'hb194));
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        stat;
        // Halt while awake: debug active, wait-stop stays low
        host.send(`CMD_HALT, 16'h0000, r, f);
        chk(16'(f), 16'h0002);
        ctl = 64;
        stat;
        for (i = 0; i < 4; i++) begin
            a = $urandom;
            host.send(`CMD_MATCH_LOAD, a[15:0], r, f);
            host.send(`CMD_MATCH_FETCH, 16'h0000, r, f);
            chk(r, a[15:0]);
            chk(match_addr_o, a[15:0]);
        end
        a = $urandom;
        host.send(`CMD_CTRL_LOAD, a[15:0], r, f);
        ctl = a & 248;
        @(negedge sys_clk_i);
        chk(16'({match_enable_o, debug_active_o, force_tag_select_o}), 16'({a[7], a[6], a[3]}));
        stat;
        cpu_force_reset_wr_i <= 1'b1;
        cpu_force_reset_data_i <= 8'(a | 1);
        @(posedge sys_clk_i);
        cpu_force_reset_wr_i <= 1'b0;
        host.send(`CMD_FORCE_FETCH, 16'h0000, r, f);
        chk(r, 16'h0000);
        chk(16'(target_reset_o), 16'h0000);
        host.send(4'hf, 16'h0000, r, f);
        chk(16'(f), 16'h0004);
        for (i = 0; i < 2; i++) begin
            host.send(`CMD_MEM_STORE, 16'(i), r, f);
            chk(16'(f), 16'h0001);
            repeat (2) @(posedge sys_clk_i);
            chk(16'(target_reset_o), 16'(i));
            repeat (10) @(posedge sys_clk_i);
        end
        cpu_sleep_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        ws = 1;
        stat;
        host.send(`CMD_MEM_FETCH, 16'h0000, r, f);
        chk(16'(f), 16'h0004);
        sleep_access_fail = 1;
        stat;
        host.send(`CMD_HALT, 16'h0000, r, f);
        chk(16'(f), 16'h0002);
        ctl = ctl | 64;
        cpu_sleep_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        stat;
        // Recovery: retry the lost access, then resume user code
        host.send(`CMD_MEM_FETCH, 16'h0000, r, f);
        chk(16'(f), 16'h0001);
        host.send(`CMD_CTRL_LOAD, 16'h0000, r, f);
        {ctl, ws, sleep_access_fail} = 0;
        stat;
        cpu_sleep_enter_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        host.send(`CMD_MEM_FETCH, 16'h0000, r, f);
        chk(16'(f), 16'h0004);
        sleep_access_fail = 1;
        stat;
        cpu_sleep_enter_i <= 1'b0;
        host.send(`CMD_CTRL_LOAD, 16'h0000, r, f);
        sleep_access_fail = 0;
        stat;
        complete_run;
    end
endmodule
